// ==== verilog/cps_suspend_ctrl.sv ====
// suspend sequencer with coprocessor handshake, top of the block
module cps_suspend_ctrl
  import cps_pkg::*;
#(
  parameter int MAX_PENDING = 2
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        suspend_request_n,
  input  wire logic [7:0]  config_reg_zero,
  input  wire logic        instr_retire,
  input  wire logic        pipe_empty,
  input  wire logic        halt_instruction,
  input  wire logic        halt_ready_n,
  input  wire logic        nmi,
  input  wire logic        maskable_irq,
  input  wire logic        irq_enable,
  input  wire logic        flush_n,
  input  wire logic        hold_req,
  input  wire logic        bus_hold_ack,
  input  wire logic        copro_busy_n,
  input  wire logic        copro_error_n,
  input  wire logic        copro_operand_req,
  input  wire logic        copro_start,
  input  wire logic        copro_write,
  input  wire logic        copro_use_hi,
  input  wire logic        ready_n,
  output logic             suspend_ack_n,
  output logic             suspend_ack_oe,
  output logic             suspended,
  output logic             fetch_stall,
  output logic             hold_grant_ok,
  output logic             nmi_pending,
  output logic             irq_pending,
  output logic             flush_pending,
  output logic             copro_busy,
  output logic             copro_error,
  output logic             copro_operand_pend,
  output logic             copro_cycle_busy,
  output logic             copro_cycle_done,
  output logic [31:0]      copro_addr,
  output logic             copro_addr_oe,
  output logic             copro_write_out
);
  typedef struct packed {
    logic       phase1;
    cps_state_t state;
    logic [4:0] cnt;
    logic [1:0] retired;
    logic       ack;
    logic       nmi_seen;
    logic       nmi_pend;
    logic       irq_pend;
    logic       flush_pend;
  } cps_top_t;
  cps_top_t st_reg;
  cps_top_t st_next;

  logic phase2;
  logic req_active;
  logic wake;
  logic in_suspend_request_n;
  cps_copro_if copro ();

  // clamp a counter step to five bits
  function automatic logic [4:0] cnt_inc(input logic [4:0] c);
    cnt_inc = (c == 5'h1f) ? c : c + 5'h01;
  endfunction : cnt_inc

  // internal phase toggles every input clock; no clock enable, so a stopped
  // clock freezes everything in place
  assign phase2 = !st_reg.phase1;
  assign req_active = !suspend_request_n && config_reg_zero[SUSPEND_REQUEST_N_BIT_POS];
  assign wake = (nmi && !st_reg.nmi_seen) || (maskable_irq && irq_enable);
  assign in_suspend_request_n = st_reg.state == CPS_SUSPEND_REQUEST_N_REQ || st_reg.state == CPS_SUSPEND_REQUEST_N_HALT;

  always_comb begin
    st_next = st_reg;
    st_next.phase1 = !st_reg.phase1;
    if (st_reg.cnt != 5'h1f) begin
      st_next.cnt = cnt_inc(st_reg.cnt);
    end
    if (phase2) begin
      st_next.nmi_seen = nmi;
      if (in_suspend_request_n || st_reg.state == CPS_EXIT_REQ || st_reg.state == CPS_EXIT_HALT) begin
        if (nmi && !st_reg.nmi_seen && st_reg.state != CPS_SUSPEND_REQUEST_N_HALT) begin
          st_next.nmi_pend = 1'b1;
        end
        if (maskable_irq && irq_enable && st_reg.state == CPS_SUSPEND_REQUEST_N_REQ) begin
          st_next.irq_pend = 1'b1;
        end
        if (!flush_n) begin
          st_next.flush_pend = 1'b1;
        end
      end
      case (st_reg.state)
        CPS_RUN: begin
          if (halt_instruction && !halt_ready_n) begin
            st_next.state = CPS_HALT_ENTER;
            st_next.cnt   = CNT_ZERO;
          end else if (req_active && !bus_hold_ack) begin
            st_next.state   = CPS_DRAIN;
            st_next.cnt     = CNT_ZERO;
            st_next.retired = 2'b00;
          end
        end
        CPS_DRAIN: begin
          if (!req_active) begin
            st_next.state = CPS_RUN;
          end else if (pipe_empty ||
                       st_reg.retired == 2'(MAX_PENDING)) begin
            st_next.state = CPS_WAIT_IDLE;
          end else if (instr_retire) begin
            st_next.retired = st_reg.retired + 2'b01;
          end
        end
        CPS_WAIT_IDLE: begin
          if (!req_active) begin
            st_next.state = CPS_RUN;
          end else if (!copro.busy && !copro_cycle_busy &&
                       st_reg.cnt >= 5'(REQ_MIN_CLKS)) begin
            st_next.state = CPS_SUSPEND_REQUEST_N_REQ;
            st_next.ack   = 1'b1;
          end
        end
        CPS_SUSPEND_REQUEST_N_REQ: begin
          if (suspend_request_n) begin
            st_next.state = CPS_EXIT_REQ;
            st_next.cnt   = CNT_ZERO;
          end
        end
        CPS_EXIT_REQ: begin
          if (st_reg.cnt == 5'(REQ_EXIT_CLKS - 1)) begin
            st_next.ack   = 1'b0;
            st_next.state = CPS_RUN;
          end
        end
        CPS_HALT_ENTER: begin
          if (!copro.busy || st_reg.cnt >= 5'(HALT_MAX_CLKS - 3)) begin
            st_next.state = CPS_SUSPEND_REQUEST_N_HALT;
            st_next.ack   = 1'b1;
          end
        end
        CPS_SUSPEND_REQUEST_N_HALT: begin
          if (wake) begin
            st_next.state = CPS_EXIT_HALT;
            st_next.cnt   = CNT_ZERO;
          end
        end
        CPS_EXIT_HALT: begin
          if (st_reg.cnt == 5'(HALT_EXIT_CLKS - 1)) begin
            st_next.ack   = 1'b0;
            st_next.state = CPS_RUN;
          end
        end
        default: st_next.state = CPS_RUN;
      endcase
    end
    if (st_reg.state == CPS_RUN && !in_suspend_request_n) begin
      st_next.nmi_pend   = st_next.nmi_pend & !(instr_retire && st_reg.nmi_pend);
      st_next.irq_pend   = st_next.irq_pend & !(instr_retire && st_reg.irq_pend);
      st_next.flush_pend = st_next.flush_pend & !(instr_retire && st_reg.flush_pend);
    end
  end

  // state stays in flops only; a stopped clock samples nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{phase1: 1'b1, state: CPS_RUN, cnt: CNT_ZERO, retired: 2'b00,
                  ack: 1'b0, nmi_seen: 1'b0, nmi_pend: 1'b0, irq_pend: 1'b0,
                  flush_pend: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  cps_copro_sync u_sync (
    .clk               (clk),
    .rst               (rst),
    .phase1            (st_reg.phase1),
    .copro_busy_n      (copro_busy_n),
    .copro_error_n     (copro_error_n),
    .copro_operand_req (copro_operand_req),
    .sync              (copro.src)
  );

  cps_copro_cycle u_cycle (
    .clk          (clk),
    .rst          (rst),
    .phase1       (st_reg.phase1),
    .start        (copro_start && !in_suspend_request_n),
    .write        (copro_write),
    .use_hi       (copro_use_hi),
    .ready_n      (ready_n),
    .bus_hold_ack (bus_hold_ack),
    .busy         (copro_cycle_busy),
    .done         (copro_cycle_done),
    .addr         (copro_addr),
    .addr_oe      (copro_addr_oe),
    .write_out    (copro_write_out)
  );

  assign suspend_ack_n      = !st_reg.ack;
  assign suspend_ack_oe     = 1'b1;
  assign suspended          = st_reg.ack;
  assign fetch_stall        = st_reg.state != CPS_RUN;
  assign hold_grant_ok      = hold_req;
  assign nmi_pending        = st_reg.nmi_pend;
  assign irq_pending        = st_reg.irq_pend;
  assign flush_pending      = st_reg.flush_pend;
  assign copro_busy         = copro.busy;
  assign copro_error        = copro.error;
  assign copro_operand_pend = copro.operand_req;

  ack_phase_a: assert property (@(posedge clk) disable iff (rst)
    $changed(st_reg.ack) |-> st_reg.phase1)
    else $error("acknowledge changed outside phase 2 edge");
  ack_enable_a: assert property (@(posedge clk) disable iff (rst)
    !config_reg_zero[SUSPEND_REQUEST_N_BIT_POS] && st_reg.state == CPS_RUN && !halt_instruction
    |=> st_reg.state == CPS_RUN)
    else $error("suspend entered while disabled");
  ack_busy_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_reg.ack) && $past(st_reg.state) == CPS_WAIT_IDLE |-> !$past(copro.busy))
    else $error("acknowledge while coprocessor busy");
  ack_min_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st_reg.ack) && $past(st_reg.state) == CPS_WAIT_IDLE
    |-> !$past(st_reg.state == CPS_RUN, 2))
    else $error("acknowledge sooner than two clocks");
  req_exit_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_REQ && suspend_request_n && phase2
    |-> st_reg.ack [*5] ##1 !st_reg.ack)
    else $error("acknowledge not dropped four clocks after release");
  halt_entry_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_RUN && phase2 && halt_instruction && !halt_ready_n
    |-> ##[1:17] st_reg.ack)
    else $error("halt acknowledge later than 17 clocks");
  halt_exit_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_HALT && phase2 && wake
    |-> st_reg.ack [*8] ##1 st_reg.ack [*5] ##1 !st_reg.ack)
    else $error("halt acknowledge not dropped after 12 clocks");
  halt_stay_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_HALT && !wake |=> st_reg.ack)
    else $error("halt suspend left without interrupt");
  flush_latch_a: assert property (@(posedge clk) disable iff (rst)
    in_suspend_request_n && phase2 && !flush_n |=> st_reg.flush_pend)
    else $error("flush lost during suspend");

  suspend_request_n_ack_a: assert property (@(posedge clk) disable iff (rst)
    in_suspend_request_n |-> st_reg.ack)
    else $error("acknowledge missing while suspended");

  exit_ack_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_EXIT_REQ || st_reg.state == CPS_EXIT_HALT |-> st_reg.ack)
    else $error("acknowledge dropped before exit delay");

  run_ack_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_RUN || st_reg.state == CPS_DRAIN ||
    st_reg.state == CPS_WAIT_IDLE || st_reg.state == CPS_HALT_ENTER |-> !st_reg.ack)
    else $error("acknowledge outside suspend");

  stall_ack_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.ack |-> fetch_stall)
    else $error("fetching while acknowledged");

  drain_abort_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_DRAIN && phase2 && !req_active |=> st_reg.state == CPS_RUN)
    else $error("withdrawn request not abandoned");

  hold_refuse_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_RUN && phase2 && bus_hold_ack && !(halt_instruction && !halt_ready_n)
    |=> st_reg.state == CPS_RUN)
    else $error("request taken during hold");

  halt_take_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_RUN && phase2 && halt_instruction && !halt_ready_n
    |=> st_reg.state == CPS_HALT_ENTER)
    else $error("halt cycle not taken");

  req_take_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_RUN && phase2 && req_active && !bus_hold_ack && !halt_instruction
    |=> st_reg.state == CPS_DRAIN)
    else $error("request not taken on phase 2 edge");

  phase1_idle_a: assert property (@(posedge clk) disable iff (rst)
    !phase2 && st_reg.state == CPS_RUN |=> st_reg.state == CPS_RUN)
    else $error("request taken on phase 1 edge");

  retire_cap_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.retired <= 2'(MAX_PENDING))
    else $error("more than allowed instructions drained");

  wait_busy_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_WAIT_IDLE && phase2 && copro.busy |=> !st_reg.ack)
    else $error("acknowledge while coprocessor busy");

  wait_min_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_WAIT_IDLE && phase2 && st_reg.cnt < 5'(REQ_MIN_CLKS)
    |=> !st_reg.ack)
    else $error("acknowledge before minimum delay");

  irq_latch_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_REQ && phase2 && maskable_irq && irq_enable
    |=> st_reg.irq_pend)
    else $error("enabled interrupt lost during suspend");

  nmi_latch_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_REQ && phase2 && nmi && !st_reg.nmi_seen
    |=> st_reg.nmi_pend)
    else $error("nmi lost during suspend");

  halt_irq_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_HALT |=> $stable(st_reg.irq_pend))
    else $error("interrupt latched instead of waking");

  halt_flush_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_HALT && phase2 && !flush_n |=> st_reg.flush_pend)
    else $error("flush lost during halt suspend");

  halt_wake_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_HALT && phase2 && wake |=> st_reg.state == CPS_EXIT_HALT)
    else $error("waking interrupt ignored");

  halt_force_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_HALT_ENTER && phase2 && st_reg.cnt >= 5'(HALT_MAX_CLKS - 3)
    |=> st_reg.ack)
    else $error("halt entry not forced in time");

  copro_gate_a: assert property (@(posedge clk) disable iff (rst)
    in_suspend_request_n && !copro_cycle_busy |=> !copro_cycle_busy)
    else $error("coprocessor cycle started while suspended");

  req_release_a: assert property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_SUSPEND_REQUEST_N_REQ && phase2 && suspend_request_n
    |=> st_reg.state == CPS_EXIT_REQ)
    else $error("released request not seen");

  // a drain cut short by a withdrawn request must land back in run
  drain_abort_c: cover property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_DRAIN ##1 st_reg.state == CPS_RUN);
  wait_busy_c: cover property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_WAIT_IDLE && copro.busy);

  req_suspend_request_n_c: cover property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_EXIT_REQ ##4 st_reg.state == CPS_RUN);
  halt_suspend_request_n_c: cover property (@(posedge clk) disable iff (rst)
    st_reg.state == CPS_EXIT_HALT ##12 st_reg.state == CPS_RUN);
  copro_cyc_c: cover property (@(posedge clk) disable iff (rst) copro_cycle_done);
endmodule : cps_suspend_ctrl

// ==== verilog/cps_pkg.sv ====
// constants and types shared by the coprocessor port and suspend controller
// Functional notes
// - finish current and decoded pending instructions and bus cycles before suspending.
// - request suspend waits for coprocessor not busy, then acknowledges.
// - suspend request ignored unless suspend enable bit of config reg zero set.
// - suspend request sampled on the clock edge starting phase 2.
// - at least two clocks from request sampled to acknowledge asserted.
// - at most two further instructions complete before acknowledge.
// - acknowledge drops exactly four clocks after request sampled inactive.
// - request during bus hold acknowledge may or may not suspend.
// - request suspend still grants hold and latches flush, nmi, enabled irq.
// - halt suspends, acknowledge within 17 clocks of halt cycle ready.
// - halt suspend ends only on nmi or unmasked maskable irq.
// - acknowledge drops 12 clocks after sampling the waking interrupt.
// - halt suspend still grants hold and latches flush for later.
// - fully static logic; clock may stop anywhere without state loss.
// - with clock stopped no input is sampled; stays suspended.
// - coprocessor instructions run io cycles to two dedicated addresses.
// - coprocessor cycles read or write, ended by ready, earliest second state.
// - busy, error, operand request sampled at start of phase 1.
// - acknowledge changes only at the start of phase 2.
// - in hold acknowledge keep driving acknowledge and hold ack, float others; only copro_addr floats here, copro_write_out stays driven.
package cps_pkg;
  localparam logic [31:0] COPRO_ADDR_LO  = 32'h800000f8;
  localparam logic [31:0] COPRO_ADDR_HI  = 32'h800000fc;
  localparam int          SUSPEND_REQUEST_N_BIT_POS   = 0;
  localparam int          REQ_MIN_CLKS   = 2;
  localparam int          REQ_EXIT_CLKS  = 4;
  localparam int          HALT_MAX_CLKS  = 17;
  localparam int          HALT_EXIT_CLKS = 12;
  localparam logic [4:0]  CNT_ZERO       = 5'h00;

  typedef enum logic [2:0] {
    CPS_RUN, CPS_DRAIN, CPS_WAIT_IDLE, CPS_SUSPEND_REQUEST_N_REQ, CPS_EXIT_REQ,
    CPS_HALT_ENTER, CPS_SUSPEND_REQUEST_N_HALT, CPS_EXIT_HALT
  } cps_state_t;

  typedef enum logic [1:0] {CPS_IO_IDLE, CPS_IO_T1, CPS_IO_T2} cps_io_state_t;
endpackage : cps_pkg

// ==== verilog/cps_copro_if.sv ====
// synchronized coprocessor status bundle between modules
interface cps_copro_if;
  logic busy;
  logic error;
  logic operand_req;
  modport src (output busy, output error, output operand_req);
  modport dst (input  busy, input  error, input  operand_req);
endinterface : cps_copro_if

// ==== verilog/cps_copro_sync.sv ====
// two-stage synchronizer for the coprocessor status inputs, sampled in phase 1
module cps_copro_sync
  import cps_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic phase1,
  input  wire logic copro_busy_n,
  input  wire logic copro_error_n,
  input  wire logic copro_operand_req,
  cps_copro_if.src  sync
);
  typedef struct packed {
    logic [2:0] meta;
    logic [2:0] stable;
  } cps_sync_t;
  cps_sync_t st_reg;
  cps_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    if (phase1) begin
      st_next.meta   = {~copro_busy_n, ~copro_error_n, copro_operand_req};
      st_next.stable = st_reg.meta;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync.busy        = st_reg.stable[2];
  assign sync.error       = st_reg.stable[1];
  assign sync.operand_req = st_reg.stable[0];
endmodule : cps_copro_sync

// ==== verilog/cps_copro_cycle.sv ====
// automatic io cycle sequencer to the two coprocessor addresses
module cps_copro_cycle
  import cps_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        phase1,
  input  wire logic        start,
  input  wire logic        write,
  input  wire logic        use_hi,
  input  wire logic        ready_n,
  input  wire logic        bus_hold_ack,
  output logic             busy,
  output logic             done,
  output logic [31:0]      addr,
  output logic             addr_oe,
  output logic             write_out
);
  typedef struct packed {
    cps_io_state_t io;
    logic [31:0]   addr;
    logic          wr;
    logic          done;
  } cps_cyc_t;
  cps_cyc_t st_reg;
  cps_cyc_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (phase1) begin
      case (st_reg.io)
        CPS_IO_IDLE: begin
          if (start && !bus_hold_ack) begin
            st_next.io   = CPS_IO_T1;
            st_next.addr = use_hi ? COPRO_ADDR_HI : COPRO_ADDR_LO;
            st_next.wr   = write;
          end
        end
        CPS_IO_T1: st_next.io = CPS_IO_T2;
        CPS_IO_T2: begin
          if (!ready_n) begin
            st_next.io   = CPS_IO_IDLE;
            st_next.done = 1'b1;
          end
        end
        default: st_next.io = CPS_IO_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '{io: CPS_IO_IDLE, addr: 32'h00000000, wr: 1'b0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy      = st_reg.io != CPS_IO_IDLE;
  assign done      = st_reg.done;
  assign addr      = st_reg.addr;
  assign addr_oe   = !bus_hold_ack;
  assign write_out = st_reg.wr;

  copro_ready_a: assert property (@(posedge clk) disable iff (rst)
    (st_reg.io == CPS_IO_T1 && phase1) |=> !done)
    else $error("coprocessor cycle ended in first state");
  copro_addr_a: assert property (@(posedge clk) disable iff (rst)
    busy |-> (addr == COPRO_ADDR_LO || addr == COPRO_ADDR_HI))
    else $error("coprocessor cycle at wrong address");
endmodule : cps_copro_cycle

// ==== verif/cps_copro_model.sv ====
// coprocessor model: status lines and ready for the automatic io cycles
module cps_copro_model (
  input  wire logic       clk,
  input  wire logic       busy_cmd,
  input  wire logic       error_cmd,
  input  wire logic       opreq_cmd,
  input  wire logic [3:0] ready_wait,
  input  wire logic       cycle_busy,
  input  wire logic       cycle_done,
  output logic            copro_busy_n,
  output logic            copro_error_n,
  output logic            copro_operand_req,
  output logic            ready_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wait_cnt = 4'h0;
  assign copro_busy_n      = ~busy_cmd;
  assign copro_error_n     = ~error_cmd;
  assign copro_operand_req = opreq_cmd;
  initial ready_n = 1'h1;
  // ready stays low until the done pulse is seen, so a late sample never misses it
  always @(posedge clk) begin
    if (cycle_done) begin
      ready_n  <= 1'h1;
      wait_cnt <= 4'h0;
    end else if (cycle_busy) begin
      if (wait_cnt >= ready_wait) begin
        ready_n <= 1'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : cps_copro_model

// ==== verif/tb_top.sv ====
// self-checking bench for the suspend sequencer and coprocessor port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cps_pkg::*;
  typedef struct packed {logic wr; logic hi; logic [3:0] wt;} cps_row_t;
  logic        clk = 1'h0;
  logic        clk_en = 1'h1;
  logic        rst = 1'h1;
  logic        suspend_request_n, instr_retire, pipe_empty, halt_instruction, halt_ready_n;
  logic        nmi, maskable_irq, irq_enable, flush_n, hold_req, bus_hold_ack, ready_n;
  logic        copro_busy_n, copro_error_n, copro_operand_req;
  logic        copro_start, copro_write, copro_use_hi;
  logic [7:0]  config_reg_zero;
  logic [2:0]  stat_cmd;
  logic [3:0]  ready_wait;
  logic        suspend_ack_n, suspend_ack_oe, suspended, fetch_stall, hold_grant_ok;
  logic        nmi_pending, irq_pending, flush_pending, copro_busy, copro_error;
  logic        copro_operand_pend, copro_cycle_busy, copro_cycle_done, copro_addr_oe;
  logic        copro_write_out;
  logic [31:0] copro_addr;
  int          err_count = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          ph_cnt = 0;
  int          n;
  cps_row_t    rows [4] = '{'{1'h0, 1'h0, 4'h0}, '{1'h1, 1'h1, 4'h0},
                            '{1'h0, 1'h1, 4'h3}, '{1'h1, 1'h0, 4'h6}};

  cps_suspend_ctrl #(.MAX_PENDING(2)) i_dut (
    .clk, .rst, .suspend_request_n, .config_reg_zero, .instr_retire, .pipe_empty,
    .halt_instruction, .halt_ready_n, .nmi, .maskable_irq, .irq_enable, .flush_n, .hold_req,
    .bus_hold_ack, .copro_busy_n, .copro_error_n, .copro_operand_req, .copro_start,
    .copro_write, .copro_use_hi, .ready_n, .suspend_ack_n, .suspend_ack_oe, .suspended,
    .fetch_stall, .hold_grant_ok, .nmi_pending, .irq_pending, .flush_pending, .copro_busy,
    .copro_error, .copro_operand_pend, .copro_cycle_busy, .copro_cycle_done, .copro_addr,
    .copro_addr_oe, .copro_write_out);

  cps_copro_model i_copro (
    .clk, .busy_cmd(stat_cmd[2]), .error_cmd(stat_cmd[1]), .opreq_cmd(stat_cmd[0]),
    .ready_wait, .cycle_busy(copro_cycle_busy), .cycle_done(copro_cycle_done),
    .copro_busy_n, .copro_error_n, .copro_operand_req, .ready_n);

  // clock can be frozen at its low level to model a stopped input clock
  always #50 clk = clk_en ? ~clk : clk;
  // odd count before an edge marks a phase 2 edge
  always @(posedge clk or posedge rst) ph_cnt <= rst ? 0 : ph_cnt + 1;

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic to_p2();
    do @(posedge clk); while (ph_cnt[0] !== 1'h1);
  endtask : to_p2

  task automatic retire();
    @(posedge clk);
    instr_retire <= 1'h1;
    // two clocks so that exactly one phase 2 edge sees the pulse
    repeat (2) @(posedge clk);
    instr_retire <= 1'h0;
  endtask : retire

  task automatic wait_ack(input int lim);
    n = 0;
    while (suspend_ack_n !== 1'h0 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_ack

  // exit cause placed on a phase 2 edge, so it is sampled exactly two edges later
  task automatic exit_chk(input int lat, input logic by_req);
    to_p2();
    if (by_req) begin
      suspend_request_n <= 1'h1;
    end else begin
      maskable_irq <= 1'h1;
    end
    repeat (lat + 2) @(negedge clk);
    check(suspend_ack_n, 1'h0);
    @(negedge clk);
    check(suspend_ack_n, 1'h1);
    @(posedge clk);
    maskable_irq <= 1'h0;
  endtask : exit_chk

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    {suspend_request_n, halt_ready_n, flush_n, pipe_empty, irq_enable} = 5'h1f;
    {instr_retire, halt_instruction, nmi, maskable_irq, hold_req, bus_hold_ack} = 6'h0;
    {copro_start, copro_write, copro_use_hi} = 3'h0;
    config_reg_zero = 8'h01;
    stat_cmd = 3'h0;
    ready_wait = 4'h0;
    repeat (10) @(posedge clk);
    check({suspend_ack_n, nmi_pending, irq_pending, flush_pending}, 4'h8);
    rst <= 1'h0;
    for (int r = 0; r < 4; r++) begin
      @(posedge clk);
      {copro_write, copro_use_hi, ready_wait, copro_start} <= {rows[r], 1'h1};
      n = 0;
      while (copro_cycle_busy !== 1'h1 && n < 8) begin
        @(negedge clk);
        n++;
      end
      @(posedge clk);
      copro_start <= 1'h0;
      while (copro_cycle_done !== 1'h1 && n < 40) begin
        @(negedge clk);
        n++;
      end
      check({copro_addr, copro_write_out, copro_addr_oe},
            {rows[r].hi ? COPRO_ADDR_HI : COPRO_ADDR_LO, rows[r].wr, 1'h1});
      check(n >= 4 && n < 40, 1'h1);
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      stat_cmd <= 3'h1 << i;
      @(negedge clk);
      check({copro_busy, copro_error, copro_operand_pend}, 3'h0);
      repeat (5) @(negedge clk);
      check({copro_busy, copro_error, copro_operand_pend}, 3'h1 << i);
      @(posedge clk);
      stat_cmd <= 3'h0;
      repeat (6) @(posedge clk);
    end
    // a request present only across a phase 1 edge must go unseen
    to_p2();
    suspend_request_n <= 1'h0;
    @(posedge clk);
    suspend_request_n <= 1'h1;
    repeat (10) @(negedge clk);
    check(suspend_ack_n, 1'h1);
    @(posedge clk);
    {config_reg_zero, suspend_request_n} <= 9'h000;
    repeat (20) @(negedge clk);
    check(suspend_ack_n, 1'h1);
    @(posedge clk);
    {config_reg_zero, bus_hold_ack} <= 9'h003;
    repeat (20) @(negedge clk);
    check(suspend_ack_n, 1'h1);
    check({suspend_ack_oe, copro_addr_oe}, 2'h2);
    @(posedge clk);
    {suspend_request_n, bus_hold_ack} <= 2'h2;
    to_p2();
    suspend_request_n <= 1'h0;
    wait_ack(30);
    check(n >= 4 && n < 30, 1'h1);
    @(posedge clk);
    {hold_req, nmi} <= 2'h3;
    repeat (4) @(negedge clk);
    check({hold_grant_ok, nmi_pending}, 2'h3);
    @(posedge clk);
    {hold_req, nmi} <= 2'h0;
    // stopped only once ack is seen low, the low-current order
    @(negedge clk);
    clk_en = 1'h0;
    #1000 maskable_irq = 1'h1;
    #1000 maskable_irq = 1'h0;
    #1000 clk_en = 1'h1;
    repeat (10) @(negedge clk);
    check(suspend_ack_n, 1'h0);
    check(irq_pending, 1'h0);
    exit_chk(4, 1'h1);
    check(nmi_pending, 1'h1);
    retire();
    @(posedge clk);
    {pipe_empty, stat_cmd, suspend_request_n} <= 5'h08;
    repeat (12) @(negedge clk);
    check(suspend_ack_n, 1'h1);
    retire();
    repeat (6) @(negedge clk);
    check(suspend_ack_n, 1'h1);
    retire();
    repeat (6) @(negedge clk);
    check(suspend_ack_n, 1'h1);
    @(posedge clk);
    stat_cmd <= 3'h0;
    wait_ack(30);
    check(suspend_ack_n, 1'h0);
    exit_chk(4, 1'h1);
    to_p2();
    {pipe_empty, halt_instruction, halt_ready_n} <= 3'h6;
    wait_ack(40);
    check(n <= 19, 1'h1);
    @(posedge clk);
    {halt_instruction, halt_ready_n, hold_req, flush_n, irq_enable, maskable_irq} <= 6'h19;
    repeat (4) @(posedge clk);
    flush_n <= 1'h1;
    repeat (20) @(negedge clk);
    check({hold_grant_ok, flush_pending}, 2'h3);
    check(suspend_ack_n, 1'h0);
    @(posedge clk);
    {maskable_irq, hold_req, irq_enable} <= 3'h1;
    exit_chk(12, 1'h0);
    check(flush_pending, 1'h1);
    finish_test();
  end
endmodule : tb_top
